// ### src/gpio_port_ext_irq.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module gpio_port_ext_irq
   import gpio_port_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [5:0] pin_in,
   output pad_t pad,
   // Alternate functions
   input wire alt_t alt,
   output logic [5:0] alt_in_val,
   // Interrupt requests and vector fetch acknowledge
   input wire logic [5:0] irq_ack,
   output logic [5:0] irq_req,
   output logic wake_req
);

   bus_state_t bus_reg;
   logic [5:0] data_reg;
   logic [5:0] dir_reg;
   logic [5:0] opt_reg;
   logic [11:0] sens_reg;
   logic [5:0] pend_reg;
   logic [5:0] pend_next;
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic [5:0] det_prev_reg;
   logic [5:0] det_in;
   logic [5:0] dir_eff;
   logic [5:0] event_hit;
   logic [5:0] sens_clr;
   logic [5:0] read_pins;
   logic [3:0] reg_idx;
   logic addr_ok;
   logic wr_fire;
   logic [31:0] rd_mux;
   logic [11:0] sens_wr;

   // Word index decode and write strobe
   assign reg_idx = paddr[5:2];
   assign addr_ok = (paddr[31:6] == 26'h0000000) && (paddr[1:0] == 2'h0)
                    && (reg_idx <= IDX_PEND);
   assign wr_fire = psel && penable && pready && pwrite && addr_ok;
   assign sens_wr = pwdata[11:0];

   // APB handshake: one access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_reg <= BUS_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         case (bus_reg)
            BUS_IDLE: begin
               if (psel && !penable) begin
                  bus_reg <= BUS_ACCESS;
                  pready <= 1'b1;
                  pslverr <= !addr_ok;
               end
            end
            BUS_ACCESS: begin
               bus_reg <= BUS_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
            default: begin
               bus_reg <= BUS_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
         endcase
      end
   end

   // Read data captured in the setup cycle
   always_comb begin
      rd_mux = 32'h00000000;
      case (reg_idx)
         IDX_DATA: rd_mux = {26'h0000000, read_pins};
         IDX_DIR: rd_mux = {26'h0000000, dir_eff};
         IDX_OPT: rd_mux = {26'h0000000, opt_reg};
         IDX_SENS: rd_mux = {20'h00000, sens_reg};
         IDX_PEND: rd_mux = {26'h0000000, pend_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite && addr_ok) begin
         prdata <= rd_mux;
      end
   end

   // Port control registers; the latch is written in any direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_reg <= DATA_RST;
         dir_reg <= DIR_RST;
         opt_reg <= OPT_RST;
         sens_reg <= SENS_RST;
      end else if (wr_fire) begin
         case (reg_idx)
            IDX_DATA: data_reg <= pwdata[5:0];
            IDX_DIR: dir_reg <= pwdata[5:0];
            IDX_OPT: opt_reg <= pwdata[5:0];
            IDX_SENS: sens_reg <= sens_wr;
            default: begin
            end
         endcase
      end
   end

   // Effective direction: output-only pin and peripheral outputs forced out
   always_comb begin
      dir_eff = dir_reg | alt.out_en;
      dir_eff[OUT_ONLY_PIN] = 1'b1;
   end

   // Two-stage input synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 6'h3F;
         sync2_reg <= 6'h3F;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Data read path per pin
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         if (alt.out_en[i] && !dir_reg[i]) begin
            read_pins[i] = alt.out_val[i];
         end else if (dir_eff[i]) begin
            read_pins[i] = data_reg[i];
         end else begin
            read_pins[i] = sync2_reg[i];
         end
      end
   end

   // Detector input held high unless input with interrupt
   always_comb begin
      det_in = ~(~dir_eff & opt_reg) | sync2_reg;
      det_in[OUT_ONLY_PIN] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         det_prev_reg <= 6'h3F;
      end else begin
         det_prev_reg <= det_in;
      end
   end

   // Event qualification per pin sensitivity
   always_comb begin
      for (int i = 0; i < PIN_COUNT; i++) begin
         case (sens_t'(sens_reg[2*i +: 2]))
            SENS_FALL_LOW: event_hit[i] = !det_in[i];
            SENS_RISE: event_hit[i] = det_in[i] && !det_prev_reg[i];
            SENS_FALL: event_hit[i] = !det_in[i] && det_prev_reg[i];
            SENS_BOTH: event_hit[i] = det_in[i] != det_prev_reg[i];
            default: event_hit[i] = 1'b0;
         endcase
         sens_clr[i] = wr_fire && (reg_idx == IDX_SENS)
                       && (sens_wr[2*i +: 2] != sens_reg[2*i +: 2]);
      end
   end

   // Pending latches: a new event wins over either clear
   assign pend_next = (pend_reg & ~irq_ack & ~sens_clr) | event_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 6'h00;
         irq_req <= 6'h00;
         wake_req <= 1'b0;
      end else begin
         pend_reg <= pend_next;
         irq_req <= pend_next;
         wake_req <= |pend_next;
      end
   end

   // Pad drive, registered from the current configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad.out <= 6'h00;
         pad.oe_n <= 6'h3F;
         pad.pull_up <= 6'h00;
         alt_in_val <= 6'h00;
      end else begin
         for (int i = 0; i < PIN_COUNT; i++) begin
            if (alt.out_en[i]) begin
               pad.out[i] <= alt.out_val[i];
               pad.oe_n[i] <= alt.out_od[i] && alt.out_val[i];
               pad.pull_up[i] <= 1'b0;
            end else if (dir_eff[i]) begin
               pad.out[i] <= data_reg[i];
               pad.oe_n[i] <= !opt_reg[i] && data_reg[i];
               pad.pull_up[i] <= 1'b0;
            end else begin
               pad.out[i] <= 1'b0;
               pad.oe_n[i] <= 1'b1;
               pad.pull_up[i] <= opt_reg[i];
            end
            alt_in_val[i] <= dir_eff[i] ? data_reg[i] : sync2_reg[i];
         end
      end
   end

   // Checks
   // Output-only pin keeps its output drive with its direction bit cleared
   property p_out_only_dir;
      @(posedge pclk) disable iff (!presetn)
      (!dir_reg[OUT_ONLY_PIN] && !alt.out_en[OUT_ONLY_PIN]) |=>
         pad.oe_n[OUT_ONLY_PIN] == ($past(data_reg[OUT_ONLY_PIN])
         && !$past(opt_reg[OUT_ONLY_PIN]));
   endproperty
   a_out_only_dir: assert property (p_out_only_dir)
      else $error("output-only pin seen as input");

   property p_ack_clear;
      @(posedge pclk) disable iff (!presetn)
      (pend_reg[0] && irq_ack[0] && !event_hit[0]) |=> !irq_req[0];
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("vector fetch did not clear pending");

   property p_sens_clear;
      @(posedge pclk) disable iff (!presetn)
      (wr_fire && reg_idx == IDX_SENS && sens_wr[1:0] != sens_reg[1:0]
       && !event_hit[0]) |=> !pend_reg[0];
   endproperty
   a_sens_clear: assert property (p_sens_clear)
      else $error("sensitivity change kept pending");

   property p_det_hold;
      @(posedge pclk) disable iff (!presetn)
      (!opt_reg[0] || dir_eff[0]) |-> det_in[0];
   endproperty
   a_det_hold: assert property (p_det_hold)
      else $error("detector input not held high");

   property p_input_off;
      @(posedge pclk) disable iff (!presetn)
      ($past(presetn) && !dir_eff[1] && !alt.out_en[1]) |=>
         (pad.oe_n[1] && pad.pull_up[1] == $past(opt_reg[1]));
   endproperty
   a_input_off: assert property (p_input_off)
      else $error("input pin driven or wrong pull-up");

   property p_open_drain;
      @(posedge pclk) disable iff (!presetn)
      (dir_reg[2] && !alt.out_en[2]) |=>
         pad.oe_n[2] == ($past(data_reg[2]) && !$past(opt_reg[2]));
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("output drive type wrong");

   property p_sync;
      @(posedge pclk) disable iff (!presetn)
      $past(presetn, 2) |-> sync2_reg == $past(pin_in, 2);
   endproperty
   a_sync: assert property (p_sync)
      else $error("synchroniser depth wrong");

   property p_read_input;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == 32'h00000000
       && !dir_eff[0] && !alt.out_en[0]) |=> prdata[0] == $past(sync2_reg[0]);
   endproperty
   a_read_input: assert property (p_read_input)
      else $error("input read not pin level");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
      event_hit[0] |=> (wake_req && irq_req[0]) [*1];
   endproperty
   a_wake: assert property (p_wake)
      else $error("event did not raise wake");

   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && bus_reg == BUS_IDLE) |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("apb answer timing wrong");

   // Peripheral input follows the latch while the pin is an output
   property p_alt_in_latch;
      @(posedge pclk) disable iff (!presetn)
      ($past(presetn) && dir_eff[4]) |=> alt_in_val[4] == $past(data_reg[4]);
   endproperty
   a_alt_in_latch: assert property (p_alt_in_latch)
      else $error("peripheral input not fed from latch");

   c_edge_irq: cover property (@(posedge pclk) disable iff (!presetn)
      !dir_eff[0] && opt_reg[0] && irq_req[0]);
   c_ack: cover property (@(posedge pclk) disable iff (!presetn)
      irq_req[1] && irq_ack[1]);
   c_alt_out: cover property (@(posedge pclk) disable iff (!presetn)
      alt.out_en[2] && !pad.oe_n[2]);
   c_sens_clear: cover property (@(posedge pclk) disable iff (!presetn)
      pend_reg[0] && sens_clr[0]);

endmodule

// ### src/gpio_port_pkg.sv
package gpio_port_pkg;

   // Port geometry
   localparam int PIN_COUNT = 6;
   localparam int OUT_ONLY_PIN = 3;
   localparam int SENS_W = 2 * PIN_COUNT;

   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_DATA = 4'h0;
   localparam logic [3:0] IDX_DIR = 4'h1;
   localparam logic [3:0] IDX_OPT = 4'h2;
   localparam logic [3:0] IDX_SENS = 4'h3;
   localparam logic [3:0] IDX_PEND = 4'h4;

   // Reset values
   localparam logic [5:0] DATA_RST = 6'h00;
   localparam logic [5:0] DIR_RST = 6'h08;
   localparam logic [5:0] OPT_RST = 6'h02;
   localparam logic [11:0] SENS_RST = 12'h000;

   // Per-pin sensitivity codes
   typedef enum logic [1:0] {
      SENS_FALL_LOW = 2'h0,
      SENS_RISE = 2'h1,
      SENS_FALL = 2'h2,
      SENS_BOTH = 2'h3
   } sens_t;

   // Pad drive towards the pins
   typedef struct packed {
      logic [5:0] out;
      logic [5:0] oe_n;
      logic [5:0] pull_up;
   } pad_t;

   // Alternate function requests from on-chip peripherals
   typedef struct packed {
      logic [5:0] out_en;
      logic [5:0] out_val;
      logic [5:0] out_od;
      logic [5:0] in_en;
   } alt_t;

   // APB slave handshake state
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACCESS = 2'b10
   } bus_state_t;

endpackage

// ### bench/pin_model.sv
`timescale 1ns/1ps
module pin_model
   import gpio_port_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Pads and far-side drivers
   input wire pad_t pad,
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_val,
   output logic [5:0] pin_in
);
   logic [5:0] flt = 6'h15;
   // Undriven lines wander every cycle
   always @(posedge pclk) begin
      flt <= ~flt;
   end
   // Resolve each wire from all drivers
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (!pad.oe_n[i]) pin_in[i] = pad.out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (pad.pull_up[i]) pin_in[i] = 1'b1;
         else pin_in[i] = flt[i];
      end
   end
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
   import gpio_port_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rdv;
   logic pready, pslverr, wake_req, errv;
   logic [5:0] pin_in, alt_in_val, irq_req, irq_ack = '0, d;
   logic [5:0] ext_en = 6'h3F, ext_val = 6'h3F;
   pad_t pad;
   alt_t alt = '0;
   int seed = 80, num_errors = 0, samples_checked = 0, cyc = 0;

   gpio_port_ext_irq DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pad(pad), .alt(alt), .alt_in_val(alt_in_val), .irq_ack(irq_ack),
      .irq_req(irq_req), .wake_req(wake_req));
   pin_model world (.pclk(pclk), .pad(pad), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in));

   // Clock
   initial begin
      forever #4 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("Errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [31:0] a,
      input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      // Values read just after an edge are those sampled at that edge
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Input read: pin levels, the output-only pin shows its latch
   function automatic logic [31:0] exp_in_rd(input logic [5:0] p,
      input logic [5:0] l);
      exp_in_rd = {26'h0, (p & 6'h37) | (l & 6'h08)};
   endfunction

   // Output drive: a low latch drives, a high one is released in open drain
   function automatic logic [5:0] exp_oe_n(input logic [5:0] l,
      input logic [5:0] pp);
      exp_oe_n = l & ~pp;
   endfunction

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask

   // Bounded wait for the request pattern; absence first waits a fixed eight cycles
   task automatic wait_irq(input logic [5:0] exp);
      int n;
      n = 0;
      if (exp == 6'h00) repeat (8) @(negedge pclk);
      while (irq_req !== exp && n < 10) begin
         @(negedge pclk);
         n++;
      end
      chk(irq_req, exp);
      chk(wake_req, |exp);
   endtask

   task automatic ack(input logic [5:0] v);
      @(posedge pclk);
      irq_ack <= v;
      @(posedge pclk);
      irq_ack <= 6'h00;
   endtask

   task automatic pins(input logic [5:0] v);
      @(posedge pclk);
      ext_val <= v;
      repeat (5) @(negedge pclk);
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(negedge pclk);
      chk(pad.oe_n, 6'h37);
      chk(pad.pull_up, 6'h02);
      rd(32'h04, 32'h08);
      rd(32'h08, 32'h02);
      // Outputs: random latch, push-pull and open drain
      for (int i = 0; i < 4; i++) begin
         d = 6'($random(seed));
         apb(1'b1, 32'h00, {26'h0, d});
         apb(1'b1, 32'h04, 32'h3F);
         apb(1'b1, 32'h08, {26'h0, {6{i[0]}}});
         repeat (2) @(negedge pclk);
         if (i[0]) chk(pad.out, d);
         chk(pad.oe_n, exp_oe_n(d, {6{i[0]}}));
         rd(32'h00, {26'h0, d});
      end
      // Inputs: reads follow the pins and latch writes stay inside, except on the output-only pin
      apb(1'b1, 32'h08, 32'h00);
      apb(1'b1, 32'h04, 32'h00);
      rd(32'h04, 32'h08);
      for (int i = 0; i < 3; i++) begin
         d = 6'($random(seed));
         pins(d);
         apb(1'b1, 32'h00, {26'h0, ~d});
         repeat (2) @(negedge pclk);
         chk(pad.oe_n, {2'b11, ~d[3], 3'b111});
         chk(pad.pull_up, 6'h00);
         rd(32'h00, exp_in_rd(d, ~d));
      end
      // Pin 0 interrupt: safe enable, falling edge, ack
      pins(6'h3F);
      apb(1'b1, 32'h0C, 32'h001);
      apb(1'b1, 32'h08, 32'h01);
      apb(1'b1, 32'h0C, 32'h002);
      wait_irq(6'h00);
      pins(6'h3E);
      wait_irq(6'h01);
      rd(32'h10, 32'h01);
      ack(6'h01);
      wait_irq(6'h00);
      pins(6'h3F);
      pins(6'h3E);
      wait_irq(6'h01);
      apb(1'b1, 32'h0C, 32'h003);
      wait_irq(6'h00);
      // Option toggled with the pin low
      apb(1'b1, 32'h0C, 32'h002);
      apb(1'b1, 32'h08, 32'h00);
      wait_irq(6'h00);
      apb(1'b1, 32'h08, 32'h01);
      wait_irq(6'h01);
      ack(6'h01);
      apb(1'b1, 32'h0C, 32'h000);
      wait_irq(6'h01);
      pins(6'h3F);
      ack(6'h01);
      wait_irq(6'h00);
      // Alternate functions
      apb(1'b1, 32'h08, 32'h00);
      apb(1'b1, 32'h00, 32'h10);
      alt <= {6'h04, 6'h04, 6'h00, 6'h10};
      pins(6'h2F);
      repeat (2) @(negedge pclk);
      chk(pad.oe_n[2], 1'b0);
      chk(pad.out[2], 1'b1);
      rd(32'h00, 32'h27);
      apb(1'b1, 32'h04, 32'h10);
      repeat (2) @(negedge pclk);
      chk(alt_in_val[4], 1'b1);
      // Unmapped place refused, nothing written
      apb(1'b1, 32'h24, 32'h3F);
      chk(errv, 1'b1);
      rd(32'h04, 32'h1C);
      close_out();
   end
endmodule
